//--- design/conv_ctrl.sv
// Converter control: enable, sampling, start, result and trim
`timescale 1ns/1ns
`default_nettype none
module conv_ctrl
    import conv_ctrl_pkg::*;
#(
    parameter int SETTLE_COUNT = SETTLE_CYCLES,
    parameter int CONV_COUNT   = CONV_CYCLES
) (
    input  wire logic                i_clk,
    input  wire logic                i_rst,
    input  wire control_s            i_ctrl,
    input  wire logic                i_start,
    input  wire logic                i_trim_wr_pos,
    input  wire logic                i_trim_wr_neg,
    input  wire logic [TRIM_W-1:0]   i_trim_wdata,
    input  wire logic [RESULT_W-1:0] i_raw_code,
    output analog_s                  o_analog,
    output logic                     o_start_bit,
    output logic                     o_ready,
    output logic                     o_done,
    output logic [RESULT_W-1:0]      o_conversion_result,
    output logic [TRIM_W-1:0]        o_positive_offset_trim,
    output logic [TRIM_W-1:0]        o_negative_offset_trim
);

    function automatic logic [RESULT_W-1:0] signed_code(
        input logic [RESULT_W-1:0] code,
        input logic                inv
    );
        signed_code = inv ? ~code : code;
    endfunction

    // Where an abort lands: settling again while the regulator stays on
    function automatic conv_state_e fallback_state(input logic reg_on);
        fallback_state = reg_on ? ST_SETTLE : ST_OFF;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Submodules

    logic settle_done;
    logic regulator_on;

    assign regulator_on = i_ctrl.regulator_enable_bit;

    settle_timer #(
        .COUNT (SETTLE_COUNT)
    ) u_settle (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_run  (regulator_on),
        .o_done (settle_done)
    );

    trim_store #(
        .W (TRIM_W)
    ) u_trim (
        .i_clk    (i_clk),
        .i_rst    (i_rst),
        .i_wr_pos (i_trim_wr_pos),
        .i_wr_neg (i_trim_wr_neg),
        .i_wdata  (i_trim_wdata),
        .o_pos    (o_positive_offset_trim),
        .o_neg    (o_negative_offset_trim)
    );

    ////////////////////////////////////////////////////////////////////////
    // Conversion sequencer

    conv_state_e         state_reg;
    conv_state_e         state_next;
    logic [CNT_W-1:0]    cnt_reg;
    logic [CNT_W-1:0]    cnt_next;
    logic                start_reg;
    logic                start_next;
    logic [RESULT_W-1:0] result_reg;
    logic [RESULT_W-1:0] result_next;
    logic                done_reg;
    logic                done_next;
    logic                enabled;
    logic                conv_end;
    logic                chop_phase_reg;
    logic                chop_phase_next;
    logic                eff_sign;

    assign enabled  = regulator_on && i_ctrl.converter_enable_bit;
    assign conv_end = (state_reg == ST_CONV)
                   && (cnt_reg >= CNT_W'(CONV_COUNT - 1));

    always_comb begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        start_next  = start_reg;
        result_next = result_reg;
        done_next   = 1'b0;
        case (state_reg)
            ST_OFF: begin
                start_next = 1'b0;
                if (regulator_on) begin
                    state_next = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                start_next = 1'b0;
                if (!regulator_on) begin
                    state_next = ST_OFF;
                end else if (settle_done && enabled) begin
                    state_next = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (!enabled) begin
                    state_next = fallback_state(regulator_on);
                    start_next = 1'b0;
                end else if (i_start) begin
                    state_next = ST_CONV;
                    start_next = 1'b1;
                    cnt_next   = '0;
                end
            end
            ST_CONV: begin
                cnt_next = cnt_reg + CNT_W'(1);
                if (!enabled) begin
                    state_next = fallback_state(regulator_on);
                    start_next = 1'b0;
                end else if (conv_end) begin
                    state_next  = ST_SAMPLE;
                    start_next  = 1'b0;
                    done_next   = 1'b1;
                    result_next = i_ctrl.input_mute_bit
                                ? MID_HIGH
                                : signed_code(i_raw_code,
                                    eff_sign);
                end
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg  <= ST_OFF;
            cnt_reg    <= '0;
            start_reg  <= 1'b0;
            result_reg <= RESULT_RESET;
            done_reg   <= 1'b0;
        end else begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            start_reg  <= start_next;
            result_reg <= result_next;
            done_reg   <= done_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Chop phase

    // Flip polarity after each finished conversion so a pair cancels offset
    always_comb begin
        if (!enabled || !i_ctrl.chop_enable_bit) begin
            chop_phase_next = 1'b0;
        end else if (done_next) begin
            chop_phase_next = ~chop_phase_reg;
        end else begin
            chop_phase_next = chop_phase_reg;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            chop_phase_reg <= 1'b0;
        end else begin
            chop_phase_reg <= chop_phase_next;
        end
    end

    assign eff_sign = i_ctrl.sign_invert_bit ^ chop_phase_reg;

    ////////////////////////////////////////////////////////////////////////
    // Analog control outputs

    analog_s analog_reg;
    analog_s analog_next;

    always_comb begin
        analog_next.regulator_on = regulator_on;
        analog_next.converter_on = regulator_on;
        analog_next.sampling     = (state_next == ST_SAMPLE);
        analog_next.load_20u     = regulator_on
                                && i_ctrl.constant_load_bit;
        analog_next.load_10u     = i_ctrl.dynamic_load_bit
                                && (state_next == ST_SAMPLE);
        analog_next.chop_on      = i_ctrl.chop_enable_bit;
        analog_next.mute_on      = i_ctrl.input_mute_bit;
        analog_next.sign_on      = eff_sign;
        analog_next.scale_x3     = i_ctrl.triple_scale_bit;
        analog_next.single_ended = i_ctrl.single_ended_select;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            analog_reg <= '0;
        end else begin
            analog_reg <= analog_next;
        end
    end

    assign o_analog            = analog_reg;
    assign o_start_bit         = start_reg;
    assign o_ready             = (state_reg == ST_SAMPLE);
    assign o_done              = done_reg;
    assign o_conversion_result = result_reg;

endmodule
`default_nettype wire

//--- design/conv_ctrl_pkg.sv
// Shared constants and carriers for the converter control block
package conv_ctrl_pkg;

    localparam int          RESULT_W        = 10;
    localparam int          SUM_W           = RESULT_W + 1;
    localparam int          TRIM_W          = 10;
    localparam int          CLK_MHZ         = 100;
    localparam int          SETTLE_US       = 20;
    localparam int          SETTLE_CYCLES   = SETTLE_US * CLK_MHZ;
    localparam int          CONV_NS         = 62;
    localparam int          CONV_CYCLES     = CONV_NS * CLK_MHZ / 1000;
    localparam int          CNT_W           = 12;
    localparam logic [9:0]  MID_LOW         = 10'h1ff;
    localparam logic [9:0]  MID_HIGH        = 10'h200;
    localparam logic [9:0]  TRIM_RESET      = 10'h200;
    localparam logic [9:0]  RESULT_RESET    = 10'h000;
    localparam int          ATTN_FACTOR     = 3;

    typedef struct packed {
        logic regulator_enable_bit;
        logic converter_enable_bit;
        logic constant_load_bit;
        logic dynamic_load_bit;
        logic chop_enable_bit;
        logic input_mute_bit;
        logic sign_invert_bit;
        logic triple_scale_bit;
        logic single_ended_select;
    } control_s;

    typedef struct packed {
        logic regulator_on;
        logic converter_on;
        logic sampling;
        logic load_20u;
        logic load_10u;
        logic chop_on;
        logic mute_on;
        logic sign_on;
        logic scale_x3;
        logic single_ended;
    } analog_s;

    typedef enum logic [1:0] {
        ST_OFF    = 2'b00,
        ST_SETTLE = 2'b01,
        ST_SAMPLE = 2'b11,
        ST_CONV   = 2'b10
    } conv_state_e;

endpackage

//--- design/trim_store.sv
// Offset trim register pair with registered read-out
`timescale 1ns/1ns
`default_nettype none
module trim_store
    import conv_ctrl_pkg::*;
#(
    parameter int W = TRIM_W
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic         i_wr_pos,
    input  wire logic         i_wr_neg,
    input  wire logic [W-1:0] i_wdata,
    output logic      [W-1:0] o_pos,
    output logic      [W-1:0] o_neg
);
    logic [W-1:0] pos_reg;
    logic [W-1:0] pos_next;
    logic [W-1:0] neg_reg;
    logic [W-1:0] neg_next;

    always_comb begin
        pos_next = i_wr_pos ? i_wdata : pos_reg;
        neg_next = i_wr_neg ? i_wdata : neg_reg;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pos_reg <= W'(TRIM_RESET);
            neg_reg <= W'(TRIM_RESET);
        end else begin
            pos_reg <= pos_next;
            neg_reg <= neg_next;
        end
    end

    assign o_pos = pos_reg;
    assign o_neg = neg_reg;
endmodule
`default_nettype wire

//--- design/settle_timer.sv
// Regulator settling timer
`timescale 1ns/1ns
`default_nettype none
module settle_timer
    import conv_ctrl_pkg::*;
#(
    parameter int COUNT = SETTLE_CYCLES
) (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_run,
    output logic      o_done
);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;

    always_comb begin
        if (!i_run) begin
            cnt_next = '0;
        end else if (cnt_reg != CNT_W'(COUNT)) begin
            cnt_next = cnt_reg + CNT_W'(1);
        end else begin
            cnt_next = cnt_reg;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign o_done = i_run && (cnt_reg == CNT_W'(COUNT));
endmodule
`default_nettype wire

//--- test/conv_ctrl_sva.sv
// Port assertions for the converter control block
`timescale 1ns/1ns
`default_nettype none
module conv_ctrl_sva
    import conv_ctrl_pkg::*;
#(
    parameter int SETTLE_COUNT = SETTLE_CYCLES,
    parameter int CONV_COUNT   = CONV_CYCLES
) (
    input wire logic                i_clk,
    input wire logic                i_rst,
    input wire control_s            i_ctrl,
    input wire logic                i_start,
    input wire logic                i_trim_wr_pos,
    input wire logic [TRIM_W-1:0]   i_trim_wdata,
    input wire logic [RESULT_W-1:0] i_raw_code,
    input wire analog_s             o_analog,
    input wire logic                o_start_bit,
    input wire logic                o_ready,
    input wire logic                o_done,
    input wire logic [RESULT_W-1:0] o_conversion_result,
    input wire logic [TRIM_W-1:0]   o_positive_offset_trim
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic [15:0] on_cnt;
    // Cycles the regulator enable has been held
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_ctrl.regulator_enable_bit) begin
            on_cnt <= 16'h0000;
        end else if (on_cnt != 16'hffff) begin
            on_cnt <= on_cnt + 16'h0001;
        end
    end
    logic ctrl_enabled;
    assign ctrl_enabled = i_ctrl.regulator_enable_bit
                       && i_ctrl.converter_enable_bit;
    AST_REG_ON: assert property (
        1 |=> o_analog.regulator_on == $past(i_ctrl.regulator_enable_bit))
        else $error("regulator state wrong");
    AST_SETTLE: assert property (
        o_ready |-> on_cnt >= SETTLE_COUNT - 1)
        else $error("ready before settling");
    AST_TAKE: assert property (
        o_ready && i_start && ctrl_enabled
        |=> o_start_bit && !o_analog.sampling && !o_ready)
        else $error("start not taken");
    AST_DONE: assert property (
        o_ready && i_start && ctrl_enabled ##1 ctrl_enabled[*6]
        |=> o_done && !o_start_bit && o_ready)
        else $error("conversion end wrong");
    AST_QUIET: assert property (
        !o_done |-> $stable(o_conversion_result))
        else $error("result moved without done");
    AST_REFUSE: assert property (
        !o_ready && !o_start_bit |=> !o_start_bit)
        else $error("start bit rose while not ready");
    AST_MUTE: assert property (
        o_done && o_analog.mute_on |-> o_conversion_result == MID_HIGH)
        else $error("muted result not mid-scale");
    AST_SIGN: assert property (
        o_done && !o_analog.mute_on |-> o_conversion_result
        == (o_analog.sign_on ? ~$past(i_raw_code) : $past(i_raw_code)))
        else $error("result sign wrong");
    AST_TRIM: assert property (
        i_trim_wr_pos |=> o_positive_offset_trim == $past(i_trim_wdata))
        else $error("trim not written");
    AST_DYN: assert property (
        o_analog.load_10u
        == (o_analog.sampling && $past(i_ctrl.dynamic_load_bit)))
        else $error("dynamic load outside sampling");
endmodule
bind conv_ctrl conv_ctrl_sva #(
    .SETTLE_COUNT (SETTLE_COUNT),
    .CONV_COUNT   (CONV_COUNT)
) sva (
    .i_clk                  (i_clk),
    .i_rst                  (i_rst),
    .i_ctrl                 (i_ctrl),
    .i_start                (i_start),
    .i_trim_wr_pos          (i_trim_wr_pos),
    .i_trim_wdata           (i_trim_wdata),
    .i_raw_code             (i_raw_code),
    .o_analog               (o_analog),
    .o_start_bit            (o_start_bit),
    .o_ready                (o_ready),
    .o_done                 (o_done),
    .o_conversion_result    (o_conversion_result),
    .o_positive_offset_trim (o_positive_offset_trim)
);
`default_nettype wire

//--- test/analog_far_side.sv
// Analog front end model: tracks a level, holds it while converting
`timescale 1ns/1ns
`default_nettype none
module analog_far_side
    import conv_ctrl_pkg::*;
(
    input  wire analog_s             i_analog,
    input  wire logic                i_clk,
    input  wire logic [RESULT_W-1:0] i_level,
    output var logic [RESULT_W-1:0]  o_raw_code
);
    initial o_raw_code = 10'h155;
    always @(posedge i_clk) begin
        if (!i_analog.converter_on) begin
            o_raw_code <= ~o_raw_code;
        end else if (i_analog.sampling) begin
            // Sign flips the input here; the block flips the code back
            o_raw_code <= i_analog.mute_on ? MID_HIGH
                        : i_analog.sign_on ? ~i_level : i_level;
        end
    end
endmodule
`default_nettype wire

//--- test/adc_conversion_control_calibration_test.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_control_calibration_test;
    import conv_ctrl_pkg::*;
    localparam int SC = 20;
    logic                i_clk = 1'b0;
    logic                i_rst = 1'b1;
    logic                i_start = 1'b0;
    logic                i_trim_wr_pos = 1'b0;
    logic                i_trim_wr_neg = 1'b0;
    logic [TRIM_W-1:0]   i_trim_wdata = 10'h000;
    logic [RESULT_W-1:0] level = 10'h2c5;
    logic [RESULT_W-1:0] i_raw_code;
    control_s            i_ctrl = 9'h000;
    analog_s             o_analog;
    logic                o_start_bit;
    logic                o_ready;
    logic                o_done;
    logic [RESULT_W-1:0] o_conversion_result;
    logic [TRIM_W-1:0]   o_positive_offset_trim;
    logic [TRIM_W-1:0]   o_negative_offset_trim;
    int                  miscompares = 0;
    int                  samples_checked = 0;
    int                  cycles = 0;
    conv_ctrl #(
        .SETTLE_COUNT (SC)
    ) dut (
        .i_clk                  (i_clk),
        .i_rst                  (i_rst),
        .i_ctrl                 (i_ctrl),
        .i_start                (i_start),
        .i_trim_wr_pos          (i_trim_wr_pos),
        .i_trim_wr_neg          (i_trim_wr_neg),
        .i_trim_wdata           (i_trim_wdata),
        .i_raw_code             (i_raw_code),
        .o_analog               (o_analog),
        .o_start_bit            (o_start_bit),
        .o_ready                (o_ready),
        .o_done                 (o_done),
        .o_conversion_result    (o_conversion_result),
        .o_positive_offset_trim (o_positive_offset_trim),
        .o_negative_offset_trim (o_negative_offset_trim)
    );
    analog_far_side far (.i_analog(o_analog), .i_clk(i_clk),
        .i_level(level), .o_raw_code(i_raw_code));
    initial forever #5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic conclude;
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic conv(input logic [9:0] exp);
        int n;
        n = 0;
        @(posedge i_clk);
        i_start <= 1'b1;
        @(posedge i_clk);
        i_start <= 1'b0;
        #1;
        chk(o_start_bit, 1'b1);
        while (o_done !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        chk(11'(n), 11'(CONV_CYCLES));
        chk({o_start_bit, o_ready}, 2'h1);
        chk(o_conversion_result, exp);
    endtask
    task automatic trim(input logic [9:0] p, input logic [9:0] q);
        @(posedge i_clk);
        i_trim_wr_pos <= 1'b1;
        i_trim_wdata <= p;
        @(posedge i_clk);
        i_trim_wr_pos <= 1'b0;
        i_trim_wr_neg <= 1'b1;
        i_trim_wdata <= q;
        @(posedge i_clk);
        i_trim_wr_neg <= 1'b0;
        #1;
        chk(o_positive_offset_trim, p);
        chk(o_negative_offset_trim, q);
    endtask
    task automatic t_start_up;
        int n;
        chk(o_positive_offset_trim, TRIM_RESET);
        @(posedge i_clk);
        i_ctrl <= 9'h181;
        i_start <= 1'b1;
        @(posedge i_clk);
        i_start <= 1'b0;
        #1;
        chk(o_start_bit, 1'b0);
        n = 0;
        while (o_ready !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        chk(n >= SC - 2 && n < 100, 1'b1);
        $display("test start_up finished");
    endtask
    task automatic t_convert;
        logic [10:0] sum;
        conv(10'h2c5);
        level <= 10'h13a;
        conv(10'h13a);
        sum = 11'(o_conversion_result);
        @(posedge i_clk);
        i_ctrl.sign_invert_bit <= 1'b1;
        tick(1);
        conv(10'h13a);
        sum = sum + 11'(o_conversion_result);
        chk(sum, 11'h274);
        @(posedge i_clk);
        i_ctrl.sign_invert_bit <= 1'b0;
        $display("test convert finished");
    endtask
    task automatic t_calibrate;
        trim(10'h200, 10'h200);
        @(posedge i_clk);
        i_ctrl.input_mute_bit <= 1'b1;
        tick(1);
        conv(10'h200);
        @(posedge i_clk);
        i_ctrl.sign_invert_bit <= 1'b1;
        tick(1);
        conv(10'h200);
        @(posedge i_clk);
        i_ctrl <= 9'h181;
        trim(10'h20e, 10'h1f4);
        trim(10'h300, 10'h300);
        trim(10'h100, 10'h100);
        $display("test calibrate finished");
    endtask
    task automatic t_modes;
        for (int v = 0; v < 2; v++) begin
            @(posedge i_clk);
            i_ctrl <= {4'hf, 1'b1, 2'h0, 1'b1, v[0]};
            tick(2);
            chk({o_analog.load_20u, o_analog.chop_on}, 2'h3);
            chk(o_analog.scale_x3, 1'b1);
            chk(o_analog.single_ended, v[0]);
            chk({o_analog.load_10u, o_analog.sampling}, 2'h3);
        end
        conv(10'h13a);
        tick(1);
        chk(o_analog.sign_on, 1'b1);
        conv(10'h13a);
        $display("test modes finished");
    endtask
    task automatic t_off;
        @(posedge i_clk);
        i_start <= 1'b1;
        @(posedge i_clk);
        i_start <= 1'b0;
        i_ctrl <= 9'h000;
        tick(10);
        chk({o_analog.regulator_on, o_start_bit, o_ready}, 3'h0);
        $display("test off finished");
    endtask
    initial begin
        repeat (10) @(posedge i_clk);
        i_rst <= 1'b0;
        tick(1);
        t_start_up();
        t_convert();
        t_calibrate();
        t_modes();
        t_off();
        conclude();
    end
endmodule
`default_nettype wire
